// file: hdl/ctt_core.v
// CPU subset: trap, transfers, test, wait and addressing modes
//
// Behaviour
// - Trap bumps PC, pushes PROG_COUNT_LOW_BYTE, PROG_COUNT_HIGH_BYTE, X, A, flags, SP down each, sets mask.
// - Trap then loads PC high then low from vector; nine cycles; only mask changes.
// - Wait clears mask, keeps other flags, one cycle, single byte.
// - After wait the core halts clocking until an interrupt request, then resumes.
// - Test compares A, X or memory to zero; V cleared, N and Z updated.
// - Index-to-stack loads pair minus one; stack-to-index plus one; two cycles, no flags.
// - Direct mode fetches one address byte within page zero; branch adds offset byte.
// - Extended mode fetches high then low address byte.
// - Word-offset indexed fetches high then low offset, adds to index pair.
// - Byte-offset indexed adds one byte to pair; plain indexed uses pair itself.
// - Stack-relative adds byte or word offset to SP, chosen by prefix byte.
// - Post-increment indexed modes bump the index pair after the operand access.
// - Moves: page zero to page zero, literal, to pointer, from pointer.
// - Relative mode adds signed offset byte to PC for branch target.
`timescale 1ns/1ps
`include "ctt_defines.vh"

module ctt_core #(
	parameter [15:0] START_PC = `CTT_START_PC,
	parameter [15:0] TRAP_VEC = `CTT_TRAP_VEC
) (
	sys_clk,      // Core clock
	reset_n,      // Async reset, active low
	mem_rdata,    // Byte read at mem_addr this cycle
	irq_req,      // Interrupt request, wakes from wait
	mem_addr_r,   // Bus address
	mem_wdata_r,  // Bus write data
	mem_we_r,     // Bus write strobe
	mem_re_r,     // Bus read strobe
	op_fetch_r,   // Opcode or prefix fetch this cycle
	clk_run_r,    // Low while halted by wait
	acc_r,        // Accumulator
	idx_r,        // Index pair
	sp_r,         // Stack pointer
	flags_r,      // Flag register
	pc_r          // Program counter
);
	input  wire        sys_clk;
	input  wire        reset_n;
	input  wire [7:0]  mem_rdata;
	input  wire        irq_req;
	output reg  [15:0] mem_addr_r;
	output reg  [7:0]  mem_wdata_r;
	output reg         mem_we_r;
	output reg         mem_re_r;
	output reg         op_fetch_r;
	output reg         clk_run_r;
	output reg  [7:0]  acc_r;
	output reg  [15:0] idx_r;
	output reg  [15:0] sp_r;
	output reg  [7:0]  flags_r;
	output reg  [15:0] pc_r;

	reg  [3:0]  st_r;
	reg         pre_r;
	reg  [2:0]  kind_r;
	reg  [1:0]  base_r;
	reg  [1:0]  mv_r;
	reg         two_r;
	reg         inc_r;
	reg  [7:0]  eah_r;
	reg  [7:0]  dat_r;
	reg  [2:0]  cnt_r;
	reg  [15:0] ea_base;
	reg  [7:0]  push_nxt;

	wire [7:0]  rd = mem_rdata;
	wire [15:0] pc_inc = pc_r + 16'h0001;
	wire [15:0] sp_m1 = sp_r - 16'h0001;
	wire [15:0] idx_p1 = idx_r + 16'h0001;
	wire [15:0] vec_lo = TRAP_VEC + 16'h0001;
	wire [8:0]  cmp_diff = {1'b0, acc_r} - {1'b0, rd};
	wire [15:0] ea_sum;
	wire [15:0] br_sum;

	////////////////////////////////////////////////////////////////////////
	// Address arithmetic

	always @*
	begin
		case (base_r)
		`CTT_B_HX: ea_base = idx_r;
		`CTT_B_SP: ea_base = sp_r;
		default:   ea_base = 16'h0000;
		endcase
	end

	ctt_add #(.W(16)) u_ea (
		.base (ea_base),
		.off  (two_r ? {eah_r, rd} : {8'h00, rd}),
		.sum  (ea_sum)
	);

	ctt_add #(.W(16)) u_br (
		.base (pc_inc),
		.off  ({{8{rd[7]}}, rd}),
		.sum  (br_sum)
	);

	// Next byte for the trap push sequence
	always @*
	begin
		case (cnt_r)
		`CTT_TS_PCL: push_nxt = pc_r[15:8];
		`CTT_TS_PCH: push_nxt = idx_r[7:0];
		`CTT_TS_X:   push_nxt = acc_r;
		default:     push_nxt = flags_r;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer

	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mem_addr_r  <= START_PC;
			mem_wdata_r <= 8'h00;
			mem_we_r    <= 1'b0;
			mem_re_r    <= 1'b1;
			op_fetch_r  <= 1'b1;
			clk_run_r   <= 1'b1;
			acc_r       <= 8'h00;
			idx_r       <= 16'h0000;
			sp_r        <= `CTT_SP_RST;
			flags_r     <= `CTT_CCR_RST;
			pc_r        <= START_PC;
			st_r        <= `CTT_ST_FETCH;
			pre_r       <= 1'b0;
			kind_r      <= `CTT_K_TST;
			base_r      <= `CTT_B_ZERO;
			mv_r        <= `CTT_MV_DD;
			two_r       <= 1'b0;
			inc_r       <= 1'b0;
			eah_r       <= 8'h00;
			dat_r       <= 8'h00;
			cnt_r       <= 3'h0;
		end
		else
		begin
			mem_we_r   <= 1'b0;
			mem_re_r   <= 1'b1;
			op_fetch_r <= 1'b0;
			case (st_r)
			`CTT_ST_FETCH:
			begin
				pc_r       <= pc_inc;
				mem_addr_r <= pc_inc;
				two_r      <= 1'b0;
				inc_r      <= 1'b0;
				base_r     <= `CTT_B_ZERO;
				if (!pre_r && rd == `CTT_OP_PREFIX)
				begin
					pre_r      <= 1'b1;
					op_fetch_r <= 1'b1;
				end
				else
				begin
					pre_r <= 1'b0;
					op_fetch_r <= 1'b1;
					case ({pre_r, rd})
					{1'b0, `CTT_OP_TRAP}:
					begin
						// PC already bumped past the opcode
						st_r        <= `CTT_ST_TRAP;
						op_fetch_r  <= 1'b0;
						cnt_r       <= `CTT_TS_PCL;
						mem_addr_r  <= sp_r;
						mem_wdata_r <= pc_inc[7:0];
						mem_we_r    <= 1'b1;
						mem_re_r    <= 1'b0;
					end
					{1'b0, `CTT_OP_A2F}:
					begin
						flags_r    <= acc_r | `CTT_CCR_ONES;
						st_r       <= `CTT_ST_PAD;
						op_fetch_r <= 1'b0;
						mem_re_r   <= 1'b0;
					end
					{1'b0, `CTT_OP_F2A}: acc_r <= flags_r;
					{1'b0, `CTT_OP_A2X}: idx_r[7:0] <= acc_r;
					{1'b0, `CTT_OP_X2A}: acc_r <= idx_r[7:0];
					{1'b0, `CTT_OP_HX2SP}, {1'b0, `CTT_OP_SP2HX}:
					begin
						if (rd == `CTT_OP_HX2SP)
							sp_r <= idx_r - 16'h0001;
						else
							idx_r <= sp_r + 16'h0001;
						st_r       <= `CTT_ST_PAD;
						op_fetch_r <= 1'b0;
						mem_re_r   <= 1'b0;
					end
					{1'b0, `CTT_OP_WAIT}:
					begin
						flags_r[`CTT_F_I] <= 1'b0;
						st_r       <= `CTT_ST_HALT;
						clk_run_r  <= 1'b0;
						op_fetch_r <= 1'b0;
						mem_re_r   <= 1'b0;
					end
					{1'b0, `CTT_OP_TST_A}, {1'b0, `CTT_OP_TST_X}:
					begin
						// Single cycle, nothing stored
						flags_r[`CTT_F_V] <= 1'b0;
						if (rd == `CTT_OP_TST_A)
						begin
							flags_r[`CTT_F_N] <= acc_r[7];
							flags_r[`CTT_F_Z] <= (acc_r == 8'h00);
						end
						else
						begin
							flags_r[`CTT_F_N] <= idx_r[7];
							flags_r[`CTT_F_Z] <= (idx_r[7:0] == 8'h00);
						end
					end
					{1'b0, `CTT_OP_TST_DIR}, {1'b0, `CTT_OP_TST_IX1}, {1'b1, `CTT_OP_TST_IX1}:
					begin
						kind_r     <= `CTT_K_TST;
						base_r     <= pre_r ? `CTT_B_SP :
							(rd == `CTT_OP_TST_IX1) ? `CTT_B_HX : `CTT_B_ZERO;
						st_r       <= `CTT_ST_OPL;
						op_fetch_r <= 1'b0;
					end
					{1'b0, `CTT_OP_TST_IX}:
					begin
						kind_r     <= `CTT_K_TST;
						mem_addr_r <= idx_r;
						st_r       <= `CTT_ST_MEM;
						op_fetch_r <= 1'b0;
					end
					{1'b0, `CTT_OP_CMP_EXT}, {1'b0, `CTT_OP_CMP_IX2}, {1'b1, `CTT_OP_CMP_IX2}:
					begin
						kind_r     <= `CTT_K_CMP;
						two_r      <= 1'b1;
						base_r     <= pre_r ? `CTT_B_SP :
							(rd == `CTT_OP_CMP_IX2) ? `CTT_B_HX : `CTT_B_ZERO;
						st_r       <= `CTT_ST_OPH;
						op_fetch_r <= 1'b0;
					end
					{1'b0, `CTT_OP_CBEQ_IX1P}:
					begin
						kind_r     <= `CTT_K_CBEQ;
						base_r     <= `CTT_B_HX;
						inc_r      <= 1'b1;
						st_r       <= `CTT_ST_OPL;
						op_fetch_r <= 1'b0;
					end
					{1'b0, `CTT_OP_CBEQ_IXP}, {1'b0, `CTT_OP_MOV_IXPD}:
					begin
						kind_r     <= (rd == `CTT_OP_CBEQ_IXP) ? `CTT_K_CBEQ : `CTT_K_MOV;
						mv_r       <= `CTT_MV_IXPD;
						inc_r      <= 1'b1;
						mem_addr_r <= idx_r;
						st_r       <= `CTT_ST_MEM;
						op_fetch_r <= 1'b0;
					end
					{1'b0, `CTT_OP_BRA}:
					begin
						kind_r     <= `CTT_K_BRA;
						st_r       <= `CTT_ST_REL;
						op_fetch_r <= 1'b0;
					end
					{1'b0, `CTT_OP_MOV_DD}, {1'b0, `CTT_OP_MOV_DIXP}, {1'b0, `CTT_OP_MOV_IMD}:
					begin
						kind_r     <= `CTT_K_MOV;
						mv_r       <= (rd == `CTT_OP_MOV_DD) ? `CTT_MV_DD :
							(rd == `CTT_OP_MOV_DIXP) ? `CTT_MV_DIXP : `CTT_MV_IMD;
						st_r       <= `CTT_ST_OPL;
						op_fetch_r <= 1'b0;
					end
					default: ;  // Opcodes outside this subset act as one-cycle no-ops
					endcase
				end
			end
			`CTT_ST_OPH:
			begin
				eah_r      <= rd;
				pc_r       <= pc_inc;
				mem_addr_r <= pc_inc;
				st_r       <= `CTT_ST_OPL;
			end
			`CTT_ST_OPL:
			begin
				pc_r <= pc_inc;
				if (kind_r == `CTT_K_MOV && mv_r == `CTT_MV_IMD)
				begin
					dat_r      <= rd;
					mem_addr_r <= pc_inc;
					st_r       <= `CTT_ST_DST;
				end
				else
				begin
					mem_addr_r <= ea_sum;
					st_r       <= `CTT_ST_MEM;
				end
			end
			`CTT_ST_MEM:
			begin
				dat_r      <= rd;
				mem_addr_r <= pc_r;
				if (inc_r && kind_r != `CTT_K_MOV)
					idx_r <= idx_p1;
				case (kind_r)
				`CTT_K_TST:
				begin
					flags_r[`CTT_F_V] <= 1'b0;
					flags_r[`CTT_F_N] <= rd[7];
					flags_r[`CTT_F_Z] <= (rd == 8'h00);
					st_r       <= `CTT_ST_FETCH;
					op_fetch_r <= 1'b1;
				end
				`CTT_K_CMP:
				begin
					flags_r[`CTT_F_V] <= (acc_r[7] & ~rd[7] & ~cmp_diff[7]) |
						(~acc_r[7] & rd[7] & cmp_diff[7]);
					flags_r[`CTT_F_N] <= cmp_diff[7];
					flags_r[`CTT_F_Z] <= (cmp_diff[7:0] == 8'h00);
					flags_r[`CTT_F_C] <= cmp_diff[8];
					st_r       <= `CTT_ST_FETCH;
					op_fetch_r <= 1'b1;
				end
				`CTT_K_CBEQ: st_r <= `CTT_ST_REL;
				default:
				begin
					if (mv_r == `CTT_MV_DIXP)
					begin
						mem_addr_r  <= idx_r;
						mem_wdata_r <= rd;
						mem_we_r    <= 1'b1;
						mem_re_r    <= 1'b0;
						st_r        <= `CTT_ST_MWR;
					end
					else
					begin
						if (mv_r == `CTT_MV_IXPD)
							idx_r <= idx_p1;
						st_r <= `CTT_ST_DST;
					end
				end
				endcase
			end
			`CTT_ST_DST:
			begin
				pc_r        <= pc_inc;
				mem_addr_r  <= {`CTT_ZERO_PAGE, rd};
				mem_wdata_r <= dat_r;
				mem_we_r    <= 1'b1;
				mem_re_r    <= 1'b0;
				st_r        <= `CTT_ST_MWR;
			end
			`CTT_ST_MWR:
			begin
				flags_r[`CTT_F_V] <= 1'b0;
				flags_r[`CTT_F_N] <= dat_r[7];
				flags_r[`CTT_F_Z] <= (dat_r == 8'h00);
				if (mv_r == `CTT_MV_DIXP)
					idx_r <= idx_p1;
				mem_addr_r <= pc_r;
				st_r       <= `CTT_ST_FETCH;
				op_fetch_r <= 1'b1;
			end
			`CTT_ST_REL:
			begin
				// Branch outcome settles here; one idle cycle follows
				if (kind_r == `CTT_K_BRA || acc_r == dat_r)
					pc_r <= br_sum;
				else
					pc_r <= pc_inc;
				mem_re_r <= 1'b0;
				st_r     <= `CTT_ST_PAD;
			end
			`CTT_ST_TRAP:
			begin
				cnt_r <= cnt_r + 3'h1;
				case (cnt_r)
				`CTT_TS_PCL, `CTT_TS_PCH, `CTT_TS_X, `CTT_TS_A:
				begin
					sp_r        <= sp_m1;
					mem_addr_r  <= sp_m1;
					mem_wdata_r <= push_nxt;
					mem_we_r    <= 1'b1;
					mem_re_r    <= 1'b0;
				end
				`CTT_TS_CCR:
				begin
					sp_r              <= sp_m1;
					flags_r[`CTT_F_I] <= 1'b1;
					mem_addr_r        <= TRAP_VEC;
				end
				`CTT_TS_VHI:
				begin
					eah_r      <= rd;
					mem_addr_r <= vec_lo;
				end
				`CTT_TS_VLO:
				begin
					// Idle ninth cycle keeps the documented length
					pc_r     <= {eah_r, rd};
					mem_re_r <= 1'b0;
				end
				default:
				begin
					mem_addr_r <= pc_r;
					st_r       <= `CTT_ST_FETCH;
					op_fetch_r <= 1'b1;
				end
				endcase
			end
			`CTT_ST_PAD:
			begin
				mem_addr_r <= pc_r;
				st_r       <= `CTT_ST_FETCH;
				op_fetch_r <= 1'b1;
			end
			`CTT_ST_HALT:
			begin
				// A request only resumes fetching at pc_r; no interrupt entry is taken
				if (irq_req)
				begin
					clk_run_r  <= 1'b1;
					mem_addr_r <= pc_r;
					st_r       <= `CTT_ST_FETCH;
					op_fetch_r <= 1'b1;
				end
				else
					mem_re_r <= 1'b0;
			end
			default:
			begin
				mem_addr_r <= pc_r;
				st_r       <= `CTT_ST_FETCH;
				op_fetch_r <= 1'b1;
			end
			endcase
		end
	end

endmodule // ctt_core

// file: shared/ctt_defines.vh
// Opcodes, states, flag positions and reset values for the CPU subset
`ifndef CTT_DEFINES_VH
`define CTT_DEFINES_VH

`define CTT_OP_PREFIX   8'h9E
`define CTT_OP_TRAP     8'h83
`define CTT_OP_A2F      8'h84
`define CTT_OP_F2A      8'h85
`define CTT_OP_A2X      8'h97
`define CTT_OP_X2A      8'h9F
`define CTT_OP_HX2SP    8'h94
`define CTT_OP_SP2HX    8'h95
`define CTT_OP_WAIT     8'h8F
`define CTT_OP_TST_DIR  8'h3D
`define CTT_OP_TST_A    8'h4D
`define CTT_OP_TST_X    8'h5D
`define CTT_OP_TST_IX1  8'h6D
`define CTT_OP_TST_IX   8'h7D
`define CTT_OP_CMP_EXT  8'hC1
`define CTT_OP_CMP_IX2  8'hD1
`define CTT_OP_CBEQ_IX1P 8'h61
`define CTT_OP_CBEQ_IXP 8'h71
`define CTT_OP_BRA      8'h20
`define CTT_OP_MOV_DD   8'h4E
`define CTT_OP_MOV_DIXP 8'h5E
`define CTT_OP_MOV_IMD  8'h6E
`define CTT_OP_MOV_IXPD 8'h7E

`define CTT_ST_FETCH    4'h0
`define CTT_ST_OPH      4'h1
`define CTT_ST_OPL      4'h2
`define CTT_ST_MEM      4'h3
`define CTT_ST_REL      4'h4
`define CTT_ST_DST      4'h5
`define CTT_ST_MWR      4'h6
`define CTT_ST_TRAP     4'h7
`define CTT_ST_PAD      4'h8
`define CTT_ST_HALT     4'h9

`define CTT_K_TST       3'h0
`define CTT_K_CMP       3'h1
`define CTT_K_CBEQ      3'h2
`define CTT_K_BRA       3'h3
`define CTT_K_MOV       3'h4

`define CTT_B_ZERO      2'h0
`define CTT_B_HX        2'h1
`define CTT_B_SP        2'h2

`define CTT_MV_DD       2'h0
`define CTT_MV_DIXP     2'h1
`define CTT_MV_IMD      2'h2
`define CTT_MV_IXPD     2'h3

`define CTT_TS_PCL      3'h0
`define CTT_TS_PCH      3'h1
`define CTT_TS_X        3'h2
`define CTT_TS_A        3'h3
`define CTT_TS_CCR      3'h4
`define CTT_TS_VHI      3'h5
`define CTT_TS_VLO      3'h6

`define CTT_F_V         7
`define CTT_F_H         4
`define CTT_F_I         3
`define CTT_F_N         2
`define CTT_F_Z         1
`define CTT_F_C         0

`define CTT_CCR_ONES    8'h60
`define CTT_CCR_RST     8'h68
`define CTT_SP_RST      16'h00FF
`define CTT_START_PC    16'h0000
`define CTT_TRAP_VEC    16'hFFFC
`define CTT_ZERO_PAGE   8'h00

`endif

// file: hdl/ctt_add.v
// Address adder shared by effective-address and branch-target paths
`timescale 1ns/1ps

module ctt_add #(
	parameter W = 16
) (
	base,   // Base address
	off,    // Offset, already extended
	sum     // Base plus offset
);
	input  wire [W-1:0] base;
	input  wire [W-1:0] off;
	output wire [W-1:0] sum;

	assign sum = base + off;

endmodule // ctt_add

// file: verification/ctt_mem_model.sv
// Byte-wide program and data memory standing beside the core
`timescale 1ns/1ps

module ctt_mem_model (
	sys_clk,     // Core clock
	mem_addr_r,  // Bus address
	mem_wdata_r, // Write data
	mem_we_r,    // Write strobe
	mem_re_r,    // Read strobe
	mem_rdata    // Read data
);
	input  wire        sys_clk;
	input  wire [15:0] mem_addr_r;
	input  wire [7:0]  mem_wdata_r;
	input  wire        mem_we_r;
	input  wire        mem_re_r;
	output wire [7:0]  mem_rdata;

	reg [7:0] mem [0:65535];
	reg [7:0] last_r = 8'h00;

	// Unread cycles show inverted data, so a stale byte is never trusted
	assign mem_rdata = mem_re_r ? mem[mem_addr_r] : ~last_r;

	always @(posedge sys_clk)
	begin
		if (mem_we_r)
			mem[mem_addr_r] <= mem_wdata_r;
		if (mem_re_r)
			last_r <= mem_rdata;
	end
endmodule // ctt_mem_model

// file: verification/ctt_core_sva.sv
// Timing and flag checker for the CPU subset core
`timescale 1ns/1ps

module ctt_core_sva #(
	parameter [15:0] TRAP_VEC = 16'hFFFC
) (
	input wire        sys_clk,     // Core clock
	input wire        reset_n,     // Async reset
	input wire [7:0]  mem_rdata,   // Read data
	input wire        irq_req,     // Wake request
	input wire [15:0] mem_addr_r,  // Bus address
	input wire [7:0]  mem_wdata_r, // Write data
	input wire        mem_we_r,    // Write strobe
	input wire        mem_re_r,    // Read strobe
	input wire        op_fetch_r,  // Opcode fetch
	input wire        clk_run_r,   // Running
	input wire [7:0]  acc_r,       // Accumulator
	input wire [15:0] idx_r,       // Index pair
	input wire [15:0] sp_r,        // Stack pointer
	input wire [7:0]  flags_r      // Flags
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	sequence s_op(logic [7:0] op);
		op_fetch_r && mem_rdata == op;
	endsequence
	sequence s_push;
		mem_we_r && !op_fetch_r;
	endsequence

	a_trap_push: assert property (s_op(8'h83) |=> s_push ##1 s_push
		##1 (s_push and mem_wdata_r == idx_r[7:0]) ##1 (s_push and mem_wdata_r == acc_r)
		##1 (s_push and (mem_wdata_r == flags_r && mem_addr_r == $past(sp_r, 4) - 16'h0004)))
		else $error("trap stacking wrong");
	a_trap_ret: assert property (s_op(8'h83) |=> mem_addr_r == $past(sp_r)
		&& {8'h00, mem_wdata_r} == (($past(mem_addr_r) + 16'h0001) & 16'h00FF))
		else $error("trap return byte wrong");
	a_trap_vec: assert property (s_op(8'h83) |-> ##6 mem_re_r && mem_addr_r == TRAP_VEC
		##1 mem_addr_r == TRAP_VEC + 16'h0001 ##1 !mem_re_r ##1 op_fetch_r)
		else $error("trap vector fetch wrong");
	a_trap_len: assert property (s_op(8'h83) |=> !op_fetch_r [*8] ##1 op_fetch_r)
		else $error("trap length wrong");
	a_trap_mask: assert property (s_op(8'h83) |-> ##6 flags_r[3]
		&& {flags_r[7:4], flags_r[2:0]} == {$past(flags_r[7:4], 6), $past(flags_r[2:0], 6)}
		&& sp_r == $past(sp_r, 6) - 16'h0005)
		else $error("trap flags or stack wrong");
	a_wait_mask: assert property (s_op(8'h8F) |=> !clk_run_r && !flags_r[3]
		&& flags_r[7:4] == $past(flags_r[7:4]) && flags_r[2:0] == $past(flags_r[2:0]))
		else $error("wait flags wrong");
	a_halt_idle: assert property (!clk_run_r |-> !mem_re_r && !mem_we_r && !op_fetch_r)
		else $error("bus active while halted");
	a_halt_wake: assert property (!clk_run_r && irq_req |-> ##[1:2] clk_run_r && op_fetch_r)
		else $error("no wake on request");
	a_tst_acc: assert property (s_op(8'h4D) |=> op_fetch_r && !flags_r[7]
		&& flags_r[2] == $past(acc_r[7]) && flags_r[1] == ($past(acc_r) == 8'h00)
		&& flags_r[4:3] == $past(flags_r[4:3]) && flags_r[0] == $past(flags_r[0]))
		else $error("accumulator test wrong");
	a_tst_dir: assert property (s_op(8'h3D) |-> ##2 mem_re_r
		&& mem_addr_r == {8'h00, $past(mem_rdata)} ##1 op_fetch_r && !flags_r[7]
		&& flags_r[2] == $past(mem_rdata[7]) && flags_r[1] == ($past(mem_rdata) == 8'h00))
		else $error("direct test wrong");
	a_stack_off: assert property (s_op(8'h9E) ##1 s_op(8'h6D) |-> ##2
		mem_addr_r == $past(sp_r) + {8'h00, $past(mem_rdata)} ##1 op_fetch_r)
		else $error("stack offset address wrong");
	a_ext_addr: assert property (s_op(8'hC1) |-> ##3 mem_re_r
		&& mem_addr_r == {$past(mem_rdata, 2), $past(mem_rdata)})
		else $error("extended address wrong");
	a_branch_tgt: assert property (s_op(8'h20) |-> ##3 op_fetch_r && mem_addr_r ==
		$past(mem_addr_r, 2) + 16'h0001 + {{8{$past(mem_rdata[7], 2)}}, $past(mem_rdata, 2)})
		else $error("branch target wrong");
	a_hx_to_sp: assert property (s_op(8'h94) |=> sp_r == $past(idx_r) - 16'h0001
		&& flags_r == $past(flags_r) ##1 op_fetch_r)
		else $error("index to stack wrong");
	a_sp_to_hx: assert property (s_op(8'h95) |=> idx_r == $past(sp_r) + 16'h0001
		&& flags_r == $past(flags_r) ##1 op_fetch_r)
		else $error("stack to index wrong");
	a_acc_flags: assert property (s_op(8'h84) |=> flags_r == ($past(acc_r) | 8'h60)
		##1 op_fetch_r)
		else $error("accumulator to flags wrong");
	a_flags_acc: assert property (s_op(8'h85) |=> acc_r == $past(flags_r)
		&& flags_r == $past(flags_r) && op_fetch_r)
		else $error("flags to accumulator wrong");
	a_acc_to_x: assert property (s_op(8'h97) |=> idx_r[7:0] == $past(acc_r)
		&& flags_r == $past(flags_r) && op_fetch_r)
		else $error("accumulator to index wrong");
endmodule // ctt_core_sva

bind ctt_core ctt_core_sva #(.TRAP_VEC(TRAP_VEC)) u_ctt_core_sva (.sys_clk(sys_clk),
	.reset_n(reset_n), .mem_rdata(mem_rdata), .irq_req(irq_req), .mem_addr_r(mem_addr_r),
	.mem_wdata_r(mem_wdata_r), .mem_we_r(mem_we_r), .mem_re_r(mem_re_r),
	.op_fetch_r(op_fetch_r), .clk_run_r(clk_run_r), .acc_r(acc_r), .idx_r(idx_r),
	.sp_r(sp_r), .flags_r(flags_r));

// file: verification/ctt_core_bench.sv
// Self-checking bench running a small program through the CPU subset core
`timescale 1ns/1ps

module ctt_core_bench;
	reg          sys_clk;
	reg          reset_n;
	reg          irq_req;
	wire [7:0]   mem_rdata;
	wire [15:0]  mem_addr_r;
	wire [7:0]   mem_wdata_r;
	wire         mem_we_r;
	wire         mem_re_r;
	wire         op_fetch_r;
	wire         clk_run_r;
	wire [7:0]   acc_r;
	wire [15:0]  idx_r;
	wire [15:0]  sp_r;
	wire [7:0]   flags_r;
	wire [15:0]  pc_r;
	integer      num_errors;
	integer      comparisons;
	integer      run;
	integer      n;
	reg  [7:0]   lit;
	reg  [7:0]   d2;
	reg  [7:0]   d4;
	reg  [7:0]   fa;
	reg  [7:0]   fc;
	reg  [223:0] img;
	reg  [39:0]  stk;

	ctt_core u_ctt_core (.sys_clk(sys_clk), .reset_n(reset_n), .mem_rdata(mem_rdata),
		.irq_req(irq_req), .mem_addr_r(mem_addr_r), .mem_wdata_r(mem_wdata_r),
		.mem_we_r(mem_we_r), .mem_re_r(mem_re_r), .op_fetch_r(op_fetch_r),
		.clk_run_r(clk_run_r), .acc_r(acc_r), .idx_r(idx_r), .sp_r(sp_r),
		.flags_r(flags_r), .pc_r(pc_r));
	ctt_mem_model u_ctt_mem_model (.sys_clk(sys_clk), .mem_addr_r(mem_addr_r),
		.mem_wdata_r(mem_wdata_r), .mem_we_r(mem_we_r), .mem_re_r(mem_re_r),
		.mem_rdata(mem_rdata));

	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	////////////////////////////////////////////////////////////////////////////
	function [7:0] tst_flags(input [7:0] v, input [7:0] f);
		tst_flags = {1'b0, f[6:3], v[7], v == 8'h00, f[0]};
	endfunction

	function [7:0] cmp_flags(input [7:0] a, input [7:0] m, input [7:0] f);
		reg [7:0] r;
		begin
			r = a - m;
			cmp_flags = {(a[7] ^ m[7]) & (a[7] ^ r[7]), f[6:3], r[7], r == 8'h00, a < m};
		end
	endfunction

	task check(input [15:0] seen, input [15:0] expd);
	begin
		comparisons = comparisons + 1;
		if (seen !== expd)
		begin
			num_errors = num_errors + 1;
			$display("[ERR] %0t seen %h expected %h", $time, seen, expd);
		end
	end
	endtask

	task finish_test;
	begin
		if (num_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask

	// Bounded wait for an opcode fetch; a hang shows up as a wrong address
	task wait_fetch(input [15:0] a);
	begin
		n = 0;
		while (!(op_fetch_r === 1'b1 && mem_addr_r === a) && n < 300)
		begin
			@(negedge sys_clk);
			n = n + 1;
		end
		check(mem_addr_r, a);
	end
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Move, test, transfers, modes, branch over a wait, trap, then wait and wake
	task run_once;
	begin
		@(negedge sys_clk);
		reset_n = 1'b0;
		img = {8'h6E, lit, 8'hC0, 8'h3D, 8'hC0, 8'h85, 8'h4D, 8'h97, 8'h4E, 8'hC0, 8'hC1,
			8'h95, 8'h94, 8'h5E, 8'hC1, 8'h7D, 8'h9E, 8'h6D, 8'h02, 8'h6D, 8'hFF, 8'hC1,
			8'h12, 8'h34, 8'h20, 8'h01, 8'h8F, 8'h83};
		for (n = 0; n < 28; n = n + 1)
			u_ctt_mem_model.mem[n] = img[223 - 8 * n -: 8];
		u_ctt_mem_model.mem[16'h0101] = d2;
		u_ctt_mem_model.mem[16'h0200] = $urandom;
		u_ctt_mem_model.mem[16'h1234] = d4;
		u_ctt_mem_model.mem[16'hFFFC] = 8'h00;
		u_ctt_mem_model.mem[16'hFFFD] = 8'h40;
		u_ctt_mem_model.mem[16'h0040] = 8'h8F;
		u_ctt_mem_model.mem[16'h0041] = 8'h84;
		u_ctt_mem_model.mem[16'h0042] = 8'h9F;
		u_ctt_mem_model.mem[16'h0043] = 8'h20;
		u_ctt_mem_model.mem[16'h0044] = 8'hFE;
		repeat (12) @(negedge sys_clk);
		reset_n = 1'b1;
		wait_fetch(16'h0013);
		check({8'h00, flags_r}, {8'h00, tst_flags(d2, 8'h68)});
		wait_fetch(16'h0015);
		check({8'h00, flags_r},
			{8'h00, tst_flags(u_ctt_mem_model.mem[16'h0200], 8'h68)});
		n = 0;
		while (clk_run_r !== 1'b0 && n < 300)
		begin
			@(negedge sys_clk);
			n = n + 1;
		end
		check({15'h0000, clk_run_r}, 16'h0000);
		repeat (3 + run) @(negedge sys_clk);
		check({15'h0000, mem_re_r}, 16'h0000);
		irq_req = 1'b1;
		wait_fetch(16'h0043);
		irq_req = 1'b0;
		fa = tst_flags(lit, 8'h68);
		fc = cmp_flags(fa, d4, 8'h68);
		stk = {8'h1C, 8'h00, 8'h01, fa, fc};
		check({8'h00, acc_r}, 16'h0001);
		check(pc_r, 16'h0043);
		check({8'h00, flags_r}, {8'h00, fa | 8'h60});
		check(sp_r, 16'h00FA);
		check(idx_r, 16'h0101);
		check({8'h00, u_ctt_mem_model.mem[16'h00C1]}, {8'h00, lit});
		check({8'h00, u_ctt_mem_model.mem[16'h0100]}, {8'h00, lit});
		for (n = 0; n < 5; n = n + 1)
			check({8'h00, u_ctt_mem_model.mem[255 - n]}, {8'h00, stk[39 - 8 * n -: 8]});
	end
	endtask

	initial
	begin
		reset_n = 1'b0;
		irq_req = 1'b0;
		num_errors = 0;
		comparisons = 0;
		n = $urandom(32'h83ce);
		for (run = 0; run < 8; run = run + 1)
		begin
			// Corner cases first: zero and negative moved byte, equal compare
			lit = (run == 0) ? 8'h00 : (run == 1) ? 8'h80 : $urandom;
			d2 = $urandom;
			d4 = (run == 0) ? tst_flags(8'h00, 8'h68) : $urandom;
			run_once;
		end
		finish_test;
	end

	initial
	begin
		#30000;
		num_errors = num_errors + 1;
		finish_test;
	end
endmodule // ctt_core_bench
